// file: inc/cto_params.svh
// Constants of the card time-out counter: register map, codes, reset values and counts.
// Contract
// - 05H halts upper stages, low keeps reloading
// - 61H stops low, 16-bit starts on write
// - 16-bit terminal count pulses, sets long flag
// - 00H stops every counter stage
// - 65H low auto-reload starts at START bit
// - Low terminal count pulses, sets flag, restarts
// - 65H 16-bit counter starts on write
// - 68H runs 24-bit on write, reloads frozen
// - 71H 16-bit starts, restarts at START bits
// - Reload writes apply from next START bit
// - 75H low and 16-bit both START-triggered
// - 7CH 24-bit START-triggered, restarts each START
// - 85H like 05H, halt 12 ETU after rx
// - E5H like 65H, low halts after 12
// - F1H like 71H, 16-bit halts after 12
// - F5H like 75H, both halt after 12
// - Reloads give 24-bit ETU count, low first
// - Unlisted codes treated as all stopped
// - Reload and config clear on reset, write-only
`ifndef CTO_PARAMS_SVH
`define CTO_PARAMS_SVH
`define CTO_IDX_CONFIG      6'h08
`define CTO_IDX_RELOAD_LOW  6'h09
`define CTO_IDX_RELOAD_MID  6'h0a
`define CTO_IDX_RELOAD_HIGH 6'h0b
`define CTO_IDX_STATUS      6'h0e
`define CTO_CODE_STOP       8'h00
`define CTO_CODE_LOW        8'h05
`define CTO_CODE_LOW_RX12   8'h85
`define CTO_CODE_HI         8'h61
`define CTO_CODE_BOTH       8'h65
`define CTO_CODE_BOTH_L12   8'he5
`define CTO_CODE_CHAIN      8'h68
`define CTO_CODE_HI_ST      8'h71
`define CTO_CODE_HI_ST12    8'hf1
`define CTO_CODE_BOTH_ST    8'h75
`define CTO_CODE_BOTH_ST12  8'hf5
`define CTO_CODE_CHAIN_ST   8'h7c
`define CTO_RST_BYTE        8'h00
`define CTO_HALT_ETU        4'd12
`define CTO_BIT_SHORT_FLAG  0
`define CTO_BIT_LONG_FLAG   1
`define CTO_BIT_LOW_RUN     2
`define CTO_BIT_HI_RUN      3
`endif

// file: inc/cto_pkg.sv
// Types shared by the card time-out counter.
package cto_pkg;
    typedef enum logic [1:0] {
        CTO_ST_IDLE  = 2'b00,
        CTO_ST_ARMED = 2'b01,
        CTO_ST_RUN   = 2'b10
    } cto_state_t;
    typedef enum logic [1:0] {
        CTO_TRIG_OFF   = 2'b00,
        CTO_TRIG_WRITE = 2'b01,
        CTO_TRIG_START = 2'b10
    } cto_trig_t;
    typedef struct packed {
        cto_trig_t low_trig;
        cto_trig_t hi_trig;
        logic      chain24;
        logic      halt_low;
        logic      halt_hi;
        logic      rx_only;
    } cto_mode_t;
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } cto_apb_req_t;
endpackage

// file: logic/cto_timer.sv
// Card time-out counter with APB register access.
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`include "cto_params.svh"
module cto_timer
    import cto_pkg::*;
#(
    parameter int LOW_W = 8,
    parameter int HI_W  = 16
) (
    input  wire logic         mclk,            // System clock, 10 MHz.
    input  wire logic         srst,            // Synchronous reset, active high.
    input  wire logic         ce,              // Clock enable; low freezes all state.
    input  wire cto_apb_req_t apb_req,         // APB request signals.
    output logic [31:0]       prdata,          // APB read data.
    output logic              pready,          // APB ready.
    output logic              pslverr,         // APB error on unmapped address.
    input  wire logic         etu_tick,        // One pulse per elapsed ETU.
    input  wire logic         start_any,       // START bit seen on I/O, either direction.
    input  wire logic         start_rx,        // START bit of a received character.
    output logic              short_irq,       // Pulse at low stage terminal count.
    output logic              long_irq,        // Pulse at upper counter terminal count.
    output logic              short_counter_expired_flag, // Sticky low expiry flag.
    output logic              long_counter_expired_flag   // Sticky upper expiry flag.
);
    localparam int FULL_W = LOW_W + HI_W;

    function automatic logic [6:0] reg_sel(input logic [7:0] addr);
        logic [6:0] sel;
        sel = 7'h00;
        if (addr[1:0] == 2'b00) begin
            case (addr[7:2])
                `CTO_IDX_CONFIG:      sel[0] = 1'b1;
                `CTO_IDX_RELOAD_LOW:  sel[1] = 1'b1;
                `CTO_IDX_RELOAD_MID:  sel[2] = 1'b1;
                `CTO_IDX_RELOAD_HIGH: sel[3] = 1'b1;
                `CTO_IDX_STATUS:      sel[4] = 1'b1;
                default:              sel[6] = 1'b1;
            endcase
        end else begin
            sel[6] = 1'b1;
        end
        return sel;
    endfunction

    function automatic cto_mode_t decode_mode(input logic [7:0] code);
        cto_mode_t m;
        m = '{CTO_TRIG_OFF, CTO_TRIG_OFF, 1'b0, 1'b0, 1'b0, 1'b0};
        case (code)
            `CTO_CODE_LOW: begin
                m.low_trig = CTO_TRIG_WRITE;
            end
            `CTO_CODE_LOW_RX12: begin
                m.low_trig = CTO_TRIG_WRITE;
                m.halt_low = 1'b1;
                m.halt_hi  = 1'b1;
                m.rx_only  = 1'b1;
            end
            `CTO_CODE_HI: begin
                m.hi_trig = CTO_TRIG_WRITE;
            end
            `CTO_CODE_BOTH: begin
                m.low_trig = CTO_TRIG_START;
                m.hi_trig  = CTO_TRIG_WRITE;
            end
            `CTO_CODE_BOTH_L12: begin
                m.low_trig = CTO_TRIG_START;
                m.hi_trig  = CTO_TRIG_WRITE;
                m.halt_low = 1'b1;
            end
            `CTO_CODE_CHAIN: begin
                m.hi_trig = CTO_TRIG_WRITE;
                m.chain24 = 1'b1;
            end
            `CTO_CODE_HI_ST: begin
                m.hi_trig = CTO_TRIG_START;
            end
            `CTO_CODE_HI_ST12: begin
                m.hi_trig = CTO_TRIG_START;
                m.halt_hi = 1'b1;
            end
            `CTO_CODE_BOTH_ST: begin
                m.low_trig = CTO_TRIG_START;
                m.hi_trig  = CTO_TRIG_START;
            end
            `CTO_CODE_BOTH_ST12: begin
                m.low_trig = CTO_TRIG_START;
                m.hi_trig  = CTO_TRIG_START;
                m.halt_low = 1'b1;
                m.halt_hi  = 1'b1;
            end
            `CTO_CODE_CHAIN_ST: begin
                m.hi_trig = CTO_TRIG_START;
                m.chain24 = 1'b1;
            end
            default: begin
                m.low_trig = CTO_TRIG_OFF;
            end
        endcase
        return m;
    endfunction

    logic [7:0]        reload_low_reg;
    logic [7:0]        reload_mid_reg;
    logic [7:0]        reload_high_reg;
    cto_mode_t         mode_reg;
    cto_state_t        low_st_reg;
    cto_state_t        hi_st_reg;
    cto_state_t        halt_st_reg;
    logic [LOW_W-1:0]  low_cnt_reg;
    logic [FULL_W-1:0] hi_cnt_reg;
    logic [3:0]        halt_cnt_reg;
    logic [31:0]       prdata_reg;
    logic              pready_reg;
    logic              pslverr_reg;
    logic              short_irq_reg;
    logic              long_irq_reg;
    logic              short_flag_reg;
    logic              long_flag_reg;

    logic [6:0]        sel;
    logic              xfer_done;
    logic              wr_done;
    logic              cfg_wr;
    cto_mode_t         mode_next;
    logic              halt_now;
    logic              halt_start;
    logic              low_expire;
    logic              hi_expire;
    logic [FULL_W-1:0] hi_load;
    logic              hi_running;

    assign sel       = reg_sel(apb_req.paddr);
    assign xfer_done = ce & apb_req.psel & apb_req.penable & pready_reg;
    assign wr_done   = xfer_done & apb_req.pwrite;
    assign cfg_wr    = wr_done & sel[0];
    assign mode_next = decode_mode(apb_req.pwdata[7:0]);
    assign hi_running = (hi_st_reg == CTO_ST_RUN);

    // The upper counter uses the reload values present at the moment it is loaded.
    assign hi_load = mode_reg.chain24 ?
                     FULL_W'({reload_high_reg, reload_mid_reg, reload_low_reg}) :
                     FULL_W'({reload_high_reg, reload_mid_reg});

    assign halt_start = mode_reg.rx_only ? start_rx : start_any;
    assign halt_now   = (halt_st_reg == CTO_ST_RUN) & etu_tick &
                        (halt_cnt_reg == (`CTO_HALT_ETU - 4'd1));

    // A count of N expires on the N-th ETU tick; zero behaves like one.
    assign low_expire = (low_st_reg == CTO_ST_RUN) & etu_tick &
                        (low_cnt_reg <= LOW_W'(1));
    assign hi_expire  = hi_running & etu_tick &
                        (hi_cnt_reg <= FULL_W'(1));

    // APB slave: no wait states, ready comes from a flop in the access phase.
    always_ff @(posedge mclk) begin
        if (srst) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
        end else if (ce) begin
            if (apb_req.psel & ~apb_req.penable & ~pready_reg) begin
                pready_reg  <= 1'b1;
                pslverr_reg <= sel[6];
                prdata_reg  <= 32'h0000_0000;
                if (sel[4] & ~apb_req.pwrite) begin
                    prdata_reg[`CTO_BIT_SHORT_FLAG] <= short_flag_reg;
                    prdata_reg[`CTO_BIT_LONG_FLAG]  <= long_flag_reg;
                    prdata_reg[`CTO_BIT_LOW_RUN]    <= (low_st_reg != CTO_ST_IDLE);
                    prdata_reg[`CTO_BIT_HI_RUN]     <= (hi_st_reg != CTO_ST_IDLE);
                end
            end else begin
                pready_reg  <= 1'b0;
                pslverr_reg <= 1'b0;
            end
        end
    end

    // Reload and configuration registers are write-only and read as zero.
    always_ff @(posedge mclk) begin
        if (srst) begin
            reload_low_reg  <= `CTO_RST_BYTE;
            reload_mid_reg  <= `CTO_RST_BYTE;
            reload_high_reg <= `CTO_RST_BYTE;
        end else if (wr_done) begin
            if (sel[1]) begin
                reload_low_reg <= apb_req.pwdata[7:0];
            end
            if (sel[2]) begin
                reload_mid_reg <= apb_req.pwdata[7:0];
            end
            if (sel[3]) begin
                reload_high_reg <= apb_req.pwdata[7:0];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            mode_reg <= decode_mode(`CTO_RST_BYTE);
        end else if (cfg_wr) begin
            mode_reg <= mode_next;
        end
    end

    // Twelve-ETU stop timer, armed by a halting code and started by a START bit.
    always_ff @(posedge mclk) begin
        if (srst) begin
            halt_st_reg  <= CTO_ST_IDLE;
            halt_cnt_reg <= 4'd0;
        end else if (ce) begin
            if (cfg_wr) begin
                halt_cnt_reg <= 4'd0;
                if (mode_next.halt_low | mode_next.halt_hi) begin
                    halt_st_reg <= CTO_ST_ARMED;
                end else begin
                    halt_st_reg <= CTO_ST_IDLE;
                end
            end else begin
                case (halt_st_reg)
                    CTO_ST_ARMED: begin
                        if (halt_start) begin
                            halt_st_reg <= CTO_ST_RUN;
                        end
                    end
                    CTO_ST_RUN: begin
                        if (halt_now) begin
                            halt_st_reg <= CTO_ST_IDLE;
                        end else if (etu_tick) begin
                            halt_cnt_reg <= halt_cnt_reg + 4'd1;
                        end
                    end
                    default: begin
                        halt_st_reg <= CTO_ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Low 8-bit stage: auto-reload counter.
    always_ff @(posedge mclk) begin
        if (srst) begin
            low_st_reg  <= CTO_ST_IDLE;
            low_cnt_reg <= '0;
        end else if (ce) begin
            if (cfg_wr) begin
                case (mode_next.low_trig)
                    CTO_TRIG_WRITE: begin
                        if (low_st_reg != CTO_ST_RUN) begin
                            low_cnt_reg <= LOW_W'(reload_low_reg);
                        end
                        low_st_reg <= CTO_ST_RUN;
                    end
                    CTO_TRIG_START: begin
                        low_st_reg <= CTO_ST_ARMED;
                    end
                    default: begin
                        low_st_reg <= CTO_ST_IDLE;
                    end
                endcase
            end else if (halt_now & mode_reg.halt_low) begin
                low_st_reg <= CTO_ST_IDLE;
            end else begin
                case (low_st_reg)
                    CTO_ST_ARMED: begin
                        if (start_any) begin
                            low_cnt_reg <= LOW_W'(reload_low_reg);
                            low_st_reg  <= CTO_ST_RUN;
                        end
                    end
                    CTO_ST_RUN: begin
                        if (low_expire) begin
                            low_cnt_reg <= LOW_W'(reload_low_reg);
                        end else if (etu_tick) begin
                            low_cnt_reg <= low_cnt_reg - LOW_W'(1);
                        end
                    end
                    default: begin
                        low_st_reg <= CTO_ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Upper stages: 16-bit counter, or 24-bit when the low stage is chained in.
    always_ff @(posedge mclk) begin
        if (srst) begin
            hi_st_reg  <= CTO_ST_IDLE;
            hi_cnt_reg <= '0;
        end else if (ce) begin
            if (cfg_wr) begin
                case (mode_next.hi_trig)
                    CTO_TRIG_WRITE: begin
                        hi_st_reg <= CTO_ST_RUN;
                        if (mode_next.chain24) begin
                            hi_cnt_reg <= FULL_W'({reload_high_reg, reload_mid_reg,
                                                   reload_low_reg});
                        end else begin
                            hi_cnt_reg <= FULL_W'({reload_high_reg, reload_mid_reg});
                        end
                    end
                    CTO_TRIG_START: begin
                        hi_st_reg <= CTO_ST_ARMED;
                    end
                    default: begin
                        hi_st_reg <= CTO_ST_IDLE;
                    end
                endcase
            end else if (halt_now & mode_reg.halt_hi) begin
                hi_st_reg <= CTO_ST_IDLE;
            end else begin
                case (hi_st_reg)
                    CTO_ST_ARMED: begin
                        if (start_any) begin
                            hi_cnt_reg <= hi_load;
                            hi_st_reg  <= CTO_ST_RUN;
                        end
                    end
                    CTO_ST_RUN: begin
                        if (start_any & (mode_reg.hi_trig == CTO_TRIG_START)) begin
                            hi_cnt_reg <= hi_load;
                        end else if (hi_expire) begin
                            if (mode_reg.hi_trig == CTO_TRIG_START) begin
                                hi_st_reg <= CTO_ST_ARMED;
                            end else begin
                                hi_st_reg <= CTO_ST_IDLE;
                            end
                        end else if (etu_tick) begin
                            hi_cnt_reg <= hi_cnt_reg - FULL_W'(1);
                        end
                    end
                    default: begin
                        hi_st_reg <= CTO_ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Expiry pulses and sticky flags; a write of one clears, a new expiry wins.
    always_ff @(posedge mclk) begin
        if (srst) begin
            short_irq_reg  <= 1'b0;
            long_irq_reg   <= 1'b0;
            short_flag_reg <= 1'b0;
            long_flag_reg  <= 1'b0;
        end else if (ce) begin
            short_irq_reg <= low_expire & ~cfg_wr;
            long_irq_reg  <= hi_expire & ~cfg_wr;
            if (low_expire & ~cfg_wr) begin
                short_flag_reg <= 1'b1;
            end else if (wr_done & sel[4] & apb_req.pwdata[`CTO_BIT_SHORT_FLAG]) begin
                short_flag_reg <= 1'b0;
            end
            if (hi_expire & ~cfg_wr) begin
                long_flag_reg <= 1'b1;
            end else if (wr_done & sel[4] & apb_req.pwdata[`CTO_BIT_LONG_FLAG]) begin
                long_flag_reg <= 1'b0;
            end
        end
    end

    assign prdata                     = prdata_reg;
    assign pready                     = pready_reg;
    assign pslverr                    = pslverr_reg;
    assign short_irq                  = short_irq_reg;
    assign long_irq                   = long_irq_reg;
    assign short_counter_expired_flag = short_flag_reg;
    assign long_counter_expired_flag  = long_flag_reg;
endmodule

// file: sim/card_timeout_counter_modes_test.sv
// Self-checking bench for the card time-out counter modes.
`timescale 1ns/1ps
`include "cto_params.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
    $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module card_timeout_counter_modes_test
    import cto_pkg::*;
;
    logic         mclk = 1'b0;
    logic         srst = 1'b1;
    logic         ce = 1'b1;
    logic         etu = 1'b0;
    logic         sa = 1'b0;
    logic         sr = 1'b0;
    cto_apb_req_t apb_req;
    logic [31:0]  prdata, rv;
    logic         pready, pslverr, si, li, sf, lf, er;
    logic [15:0]  sn = 16'h0, ln = 16'h0, s0 = 16'h0, l0 = 16'h0;
    int           fails = 0, comparisons = 0, seed = 32'h6aa67c50, lo, md;
    logic [7:0]   hc [4] = '{`CTO_CODE_LOW_RX12, `CTO_CODE_BOTH_L12,
                             `CTO_CODE_HI_ST12, `CTO_CODE_BOTH_ST12};
    always #50 mclk = ~mclk;
    always @(posedge mclk) begin
        sn <= sn + 16'(si);
        ln <= ln + 16'(li);
    end
    cto_timer u_cto_timer (.mclk(mclk), .srst(srst), .ce(ce), .apb_req(apb_req),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .etu_tick(etu),
        .start_any(sa), .start_rx(sr), .short_irq(si), .long_irq(li),
        .short_counter_expired_flag(sf), .long_counter_expired_flag(lf));
    cto_host u_cto_host (.mclk(mclk), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .apb_req(apb_req));
    function automatic int halt_short(input logic [7:0] c);
        return (c == `CTO_CODE_HI_ST12) ? 0 : 12;
    endfunction
    function automatic int halt_long(input logic [7:0] c);
        return (c == `CTO_CODE_BOTH_L12) ? 1 : 0;
    endfunction
    task automatic wr(input logic [5:0] i, input logic [7:0] d);
        u_cto_host.xfer(1'b1, {i, 2'b00}, {24'h0, d}, rv, er);
    endtask
    task automatic rd(input logic [5:0] i);
        u_cto_host.xfer(1'b0, {i, 2'b00}, 32'h0, rv, er);
    endtask
    task automatic prog(input logic [7:0] l, m, h, c);
        wr(`CTO_IDX_CONFIG, `CTO_CODE_STOP);
        wr(`CTO_IDX_RELOAD_LOW, l);
        wr(`CTO_IDX_RELOAD_MID, m);
        wr(`CTO_IDX_RELOAD_HIGH, h);
        wr(`CTO_IDX_CONFIG, c);
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge mclk) etu <= 1'b1;
            @(posedge mclk) etu <= 1'b0;
        end
    endtask
    task automatic start;
        @(posedge mclk) {sa, sr} <= 2'b11;
        @(posedge mclk) {sa, sr} <= 2'b00;
    endtask
    task automatic irqs(input int es, input int el);
        repeat (2) @(posedge mclk);
        `CHK("short_irq count", 16'(es), 16'(sn - s0))
        `CHK("long_irq count", 16'(el), 16'(ln - l0))
        s0 = sn;
        l0 = ln;
    endtask
    task results;
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        results;
    end
    initial begin
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
        rd(`CTO_IDX_STATUS);
        `CHK("status reset", 32'h0, rv)
        rd(`CTO_IDX_CONFIG);
        `CHK("config read", 32'h0, rv)
        rd(6'h0f);
        `CHK("unmapped error", 1'b1, er)
        lo = 1 + ($random(seed) & 7);
        prog(8'(lo), 8'(3 * lo + 2), 8'h0, `CTO_CODE_BOTH);
        tick(2);
        irqs(0, 0);
        start;
        tick(3 * lo);
        irqs(3, 1);
        rd(`CTO_IDX_STATUS);
        `CHK("flags set", 4'h7, rv[3:0])
        `CHK("flag pins set", 2'b11, {lf, sf})
        wr(`CTO_IDX_STATUS, 8'h03);
        rd(`CTO_IDX_STATUS);
        `CHK("flags cleared", 4'h4, rv[3:0])
        `CHK("flag pins clear", 2'b00, {lf, sf})
        wr(`CTO_IDX_CONFIG, `CTO_CODE_STOP);
        tick(2 * lo + 4);
        irqs(0, 0);
        prog(8'(lo), 8'h4, 8'h0, `CTO_CODE_BOTH);
        start;
        tick(2);
        wr(`CTO_IDX_CONFIG, `CTO_CODE_LOW);
        wr(`CTO_IDX_RELOAD_MID, 8'h03);
        tick(3 * lo);
        irqs((2 + 3 * lo) / lo, 0);
        md = 1 + ($random(seed) & 15);
        prog(8'h1, 8'(md), 8'h0, `CTO_CODE_HI);
        tick(md - 1);
        irqs(0, 0);
        tick(1);
        irqs(0, 1);
        lo = $random(seed) & 15;
        prog(8'(lo), 8'h1, 8'h0, `CTO_CODE_CHAIN);
        tick(255 + lo);
        irqs(0, 0);
        tick(1);
        irqs(0, 1);
        prog(8'h0, 8'h5, 8'h0, `CTO_CODE_HI_ST);
        tick(6);
        irqs(0, 0);
        start;
        tick(4);
        start;
        wr(`CTO_IDX_RELOAD_MID, 8'h02);
        tick(4);
        irqs(0, 0);
        tick(1);
        irqs(0, 1);
        start;
        tick(2);
        irqs(0, 1);
        prog(8'h2, 8'h3, 8'h0, `CTO_CODE_BOTH_ST);
        tick(3);
        irqs(0, 0);
        start;
        tick(6);
        irqs(3, 1);
        prog(8'h3, 8'h0, 8'h0, `CTO_CODE_CHAIN_ST);
        start;
        tick(2);
        start;
        tick(2);
        irqs(0, 0);
        tick(1);
        irqs(0, 1);
        // A transmitted START bit must not start the receive-only halt.
        prog(8'h1, 8'h0, 8'h0, `CTO_CODE_LOW_RX12);
        @(posedge mclk) sa <= 1'b1;
        @(posedge mclk) sa <= 1'b0;
        tick(14);
        irqs(14, 0);
        foreach (hc[k]) begin
            prog(8'h1, 8'h10, 8'h0, hc[k]);
            start;
            tick(20);
            irqs(halt_short(hc[k]), halt_long(hc[k]));
        end
        prog(8'h1, 8'h0, 8'h0, `CTO_CODE_LOW);
        tick(2);
        irqs(2, 0);
        // Ticks while the clock enable is low must be ignored.
        @(posedge mclk) ce <= 1'b0;
        tick(4);
        @(posedge mclk) ce <= 1'b1;
        irqs(0, 0);
        @(posedge mclk) srst <= 1'b1;
        @(posedge mclk) srst <= 1'b0;
        tick(4);
        irqs(0, 0);
        results;
    end
endmodule

// file: sim/cto_host.sv
// Host bus master model that programs the counter.
`timescale 1ns/1ps
module cto_host
    import cto_pkg::*;
(
    input  wire logic        mclk,    // Clock.
    input  wire logic        pready,  // Ready.
    input  wire logic [31:0] prdata,  // Read data.
    input  wire logic        pslverr, // Error.
    output cto_apb_req_t     apb_req  // Bus request.
);
    initial apb_req = '0;
    // Released lines show inverted data so stale values are never trusted.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge mclk);
        apb_req <= {1'b1, 1'b0, w, a, d};
        @(posedge mclk);
        apb_req.penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        r = prdata;
        e = pslverr;
        apb_req <= {3'b000, ~a, ~d};
    endtask
endmodule

// file: sim/cto_timer_sva.sv
// Port checker for the card time-out counter.
`timescale 1ns/1ps
`include "cto_params.svh"
module cto_timer_sva
    import cto_pkg::*;
(
    input wire logic         mclk,                       // Clock.
    input wire logic         srst,                       // Reset.
    input wire cto_apb_req_t apb_req,                    // Bus request.
    input wire logic [31:0]  prdata,                     // Read data.
    input wire logic         pready,                     // Ready.
    input wire logic         pslverr,                    // Error.
    input wire logic         etu_tick,                   // Unit tick.
    input wire logic         short_irq,                  // Low pulse.
    input wire logic         long_irq,                   // Upper pulse.
    input wire logic         short_counter_expired_flag, // Low flag.
    input wire logic         long_counter_expired_flag   // Upper flag.
);
    wire logic done  = apb_req.psel && apb_req.penable && pready && apb_req.pwrite;
    wire logic st_wr = done && apb_req.paddr == {`CTO_IDX_STATUS, 2'b00};
    wire logic clr_s = st_wr && apb_req.pwdata[0];
    wire logic clr_l = st_wr && apb_req.pwdata[1];
    wire logic stop  = done && apb_req.paddr == {`CTO_IDX_CONFIG, 2'b00}
                       && apb_req.pwdata[7:0] == `CTO_CODE_STOP;
    wire logic wo_rd = pready && !apb_req.pwrite && apb_req.paddr[1:0] == 2'b00
                       && apb_req.paddr[7:2] inside {[`CTO_IDX_CONFIG:`CTO_IDX_RELOAD_HIGH]};
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    a_short_flag_set: assert property (short_irq |-> short_counter_expired_flag)
        else $error("short pulse without flag");
    a_long_flag_set: assert property (long_irq |-> long_counter_expired_flag)
        else $error("long pulse without flag");
    a_short_from_tick: assert property (short_irq |-> $past(etu_tick))
        else $error("short pulse without tick");
    a_long_from_tick: assert property (long_irq |-> $past(etu_tick))
        else $error("long pulse without tick");
    a_setup_then_ready: assert property (apb_req.psel && !apb_req.penable |-> !pready ##1 pready)
        else $error("ready not in access cycle");
    a_write_only_zero: assert property (wo_rd |-> prdata == 32'h0 && !pslverr)
        else $error("write-only register read nonzero");
    // A reset also clears the flags, so the edge after a reset is excused.
    a_short_clear_only: assert property ($fell(short_counter_expired_flag)
        |-> $past(clr_s) || $past(srst))
        else $error("short flag fell without clear");
    a_long_clear_only: assert property ($fell(long_counter_expired_flag)
        |-> $past(clr_l) || $past(srst))
        else $error("long flag fell without clear");
    a_stop_quiet: assert property (stop |=> (!short_irq && !long_irq) [*3])
        else $error("pulse after stop");
endmodule
bind cto_timer cto_timer_sva u_sva (.mclk, .srst, .apb_req, .prdata, .pready, .pslverr,
    .etu_tick, .short_irq, .long_irq, .short_counter_expired_flag, .long_counter_expired_flag);
